// File: hw/bss_lerp.sv
`timescale 1ns/100ps
module bss_lerp (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Ramp channel
   bss_lerp_if.lerp lp
);
   typedef struct packed {
      logic [15:0] value;
      logic [15:0] elapsed;
      logic [31:0] err;
      logic [15:0] mag;
      logic        up;
      logic        done;
   } bss_lerp_st_t;

   bss_lerp_st_t q, d;
   logic [31:0]  errIn;

   assign lp.value = q.value;
   assign lp.done  = q.done;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      errIn = q.err;
      if (lp.load) begin
         d.value   = lp.startVal;
         d.elapsed = '0;
         d.err     = '0;
         d.up      = lp.endVal >= lp.startVal;
         d.mag     = d.up ? lp.endVal - lp.startVal
                          : lp.startVal - lp.endVal;
         d.done    = 1'b0;
      end else begin
         // Error-accumulating stepper: exact end value, no divider
         if (lp.tick && q.elapsed != lp.durMs) begin
            d.elapsed = q.elapsed + 16'h0001;
            errIn     = q.err + 32'(q.mag);
         end
         if (lp.durMs != '0 && errIn >= 32'(lp.durMs)) begin
            errIn   = errIn - 32'(lp.durMs);
            d.value = q.up ? q.value + 16'h0001 : q.value - 16'h0001;
         end
         d.err  = errIn;
         d.done = d.elapsed == lp.durMs && errIn < 32'(lp.durMs);
      end
      if (!nrst) begin
         d = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      q <= d;
   end
endmodule

// File: hw/bss_lerp_if.sv
`timescale 1ns/100ps
interface bss_lerp_if;
   logic        load;
   logic        tick;
   logic [15:0] durMs;
   logic [15:0] startVal;
   logic [15:0] endVal;
   logic [15:0] value;
   logic        done;
   modport ctl  (output load, tick, durMs, startVal, endVal,
                 input value, done);
   modport lerp (input load, tick, durMs, startVal, endVal,
                 output value, done);
endinterface

// File: hw/bss_pkg.sv
package bss_pkg;
   // Timing
   localparam int CLK_NS       = 5;
   localparam int MS_NS        = 1_000_000;
   localparam int MS_CYCLES    = MS_NS / CLK_NS;
   localparam longint CLK_HZ   = 64'd1_000_000_000 / CLK_NS;
   localparam int SEC_PER_MIN  = 60;
   localparam int SECTORS      = 6;
   localparam int POLE_PAIR    = 2;
   // Accumulator span for one commutation step at rpm*poles per cycle
   localparam logic [35:0] COMM_FULL =
      36'(CLK_HZ * SEC_PER_MIN * POLE_PAIR / SECTORS);

   localparam logic [2:0]  SECTOR_LOCK1 = 3'h0;
   localparam logic [2:0]  SECTOR_LOCK2 = 3'h1;
   localparam logic [2:0]  SECTOR_LAST  = 3'h5;
   localparam logic [4:0]  BLANK_MAX    = 5'h14;
   localparam logic [4:0]  ADV_MAX_DEG  = 5'h1E;
   localparam int          ADV_RPM_UNIT = 1000;
   localparam logic [15:0] HYST_ERPS    = 16'h0032;
   localparam logic [15:0] CROSS_MIN    = 16'h0032;
   localparam logic [15:0] CROSS_DFLT   = 16'h00FA;
   localparam logic [15:0] RAMP_MS_MIN  = 16'h01F4;
   localparam logic [15:0] RAMP_MS_MAX  = 16'h1964;
   localparam logic [6:0]  DUTY_FULL    = 7'h64;
   localparam logic [9:0]  POT_FULL     = 10'h3FF;
   localparam int          PID_FRAC     = 16;
   localparam longint      PID_MAX      = longint'(DUTY_FULL) << PID_FRAC;
   localparam logic [15:0] POLES_DFLT   = 16'h0004;
   localparam logic [15:0] SENS_DFLT    = 16'h0014;
   localparam logic [15:0] SPEED_DFLT   = 16'hFFFF;

   // Register word indices, byte address = 4 * index
   localparam int NCFG = 21;
   localparam logic [5:0] R_CTRL = 6'h00, R_POLES = 6'h01, R_BLANK = 6'h02,
      R_ADV_START = 6'h03, R_ADV_SLOPE = 6'h04, R_MAX_SPEED = 6'h05,
      R_CROSS = 6'h06, R_SYNC_SENS = 6'h07, R_LOCK1_MS = 6'h08,
      R_LOCK2_MS = 6'h09, R_LOCK1_DUTY = 6'h0A, R_LOCK2_DUTY = 6'h0B,
      R_RAMP_DUTY0 = 6'h0C, R_RAMP_DUTY1 = 6'h0D, R_RAMP_SPD0 = 6'h0E,
      R_RAMP_SPD1 = 6'h0F, R_RAMP_MS = 6'h10, R_INIT_DUTY = 6'h11,
      R_KP = 6'h12, R_KI = 6'h13, R_KD = 6'h14, R_STATUS = 6'h15,
      R_DUTY = 6'h16;
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP  = 1;
   localparam int CTRL_LOOP  = 2;
   localparam int CTRL_POT   = 3;
   localparam logic [15:0] CTRL_KEEP = 16'h000C;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [NCFG-1:0][15:0] bss_cfg_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_LOCK1 = 6'h02,
      ST_LOCK2 = 6'h04,
      ST_RAMP  = 6'h08,
      ST_RUN   = 6'h10,
      ST_FAULT = 6'h20
   } bss_state_t;
endpackage

// File: hw/bss_top.sv
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module bss_top #(
   parameter int MS_CYCLES = bss_pkg::MS_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Measurements and events
   input  wire logic [9:0]  potValue,
   input  wire logic [15:0] speedRpm,
   input  wire logic [15:0] speedErps,
   input  wire logic        sampleTick,
   input  wire logic        commEvt,
   input  wire logic        commTimerOvf,
   // Power stage
   output logic [6:0]       pwmDuty,
   output logic [2:0]       sector,
   output logic             commStep,
   output logic             motorOn,
   // Back-EMF processing control
   output logic             highSpeed,
   output logic [4:0]       phaseAdv,
   output logic             bemfValid,
   output logic             syncFault
);
   typedef struct packed {
      bss_pkg::bss_cfg_t   cfg;
      logic                awHave;
      logic [7:0]          awAddr;
      logic                wHave;
      logic [31:0]         wData;
      logic [3:0]          wStrb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic                startReq;
      logic                stopReq;
      bss_pkg::bss_state_t st;
      logic [17:0]         msCnt;
      logic [15:0]         phMs;
      logic                rampLoad;
      logic [35:0]         commAcc;
      logic [2:0]          sector;
      logic                commStep;
      logic [6:0]          duty;
      logic signed [47:0]  pidAcc;
      logic signed [16:0]  e1;
      logic signed [16:0]  e2;
      logic                highSpeed;
      logic [4:0]          phaseAdv;
      logic [4:0]          blankCnt;
      logic                bemfValid;
      logic [4:0]          ovfCnt;
      logic                fault;
      logic                motorOn;
   } bss_top_st_t;

   bss_top_st_t         q, d;
   bss_lerp_if          dutyIf ();
   bss_lerp_if          spdIf ();
   logic                msTick;
   logic [15:0]         rampMs;
   logic [15:0]         crossEff;
   logic [4:0]          blankEff;
   logic [6:0]          potDuty;
   logic [15:0]         potRef;
   logic [23:0]         advProd;
   logic [4:0]          advDeg;
   logic signed [16:0]  spdErr;
   logic signed [17:0]  pErr;
   logic signed [18:0]  dErr;
   logic signed [47:0]  pidSum;
   logic [35:0]         commNext;
   logic [5:0]          wIdx;
   logic [5:0]          rIdx;
   logic                potEn;
   logic                loopEn;

   ////////////////////////////////////////////////////////////////////
   // Derived settings
   assign msTick = q.msCnt == 18'(MS_CYCLES - 1);
   assign potEn  = q.cfg[bss_pkg::R_CTRL][bss_pkg::CTRL_POT];
   assign loopEn = q.cfg[bss_pkg::R_CTRL][bss_pkg::CTRL_LOOP];
   assign rampMs = q.cfg[bss_pkg::R_RAMP_MS] < bss_pkg::RAMP_MS_MIN ?
                   bss_pkg::RAMP_MS_MIN :
                   q.cfg[bss_pkg::R_RAMP_MS] > bss_pkg::RAMP_MS_MAX ?
                   bss_pkg::RAMP_MS_MAX : q.cfg[bss_pkg::R_RAMP_MS];
   assign crossEff = q.cfg[bss_pkg::R_CROSS] < bss_pkg::CROSS_MIN ?
                     bss_pkg::CROSS_MIN : q.cfg[bss_pkg::R_CROSS];
   assign blankEff = q.cfg[bss_pkg::R_BLANK] > 16'(bss_pkg::BLANK_MAX) ?
                     bss_pkg::BLANK_MAX : 5'(q.cfg[bss_pkg::R_BLANK]);
   // Full-scale pot reads as exactly 100 % or max speed
   assign potDuty = 7'((20'(potValue) * 20'(bss_pkg::DUTY_FULL)) /
                       20'(bss_pkg::POT_FULL));
   assign potRef  = 16'((26'(potValue) *
                         26'(q.cfg[bss_pkg::R_MAX_SPEED])) /
                        26'(bss_pkg::POT_FULL));
   assign spdErr  = $signed({1'b0, potRef}) - $signed({1'b0, speedRpm});
   assign pErr    = 18'(spdErr) - 18'(q.e1);
   assign dErr    = 19'(spdErr) - 19'(q.e1) - 19'(q.e1) + 19'(q.e2);
   // Incremental PID form keeps one accumulator for all three terms
   assign pidSum  = q.pidAcc
      + 48'(pErr * $signed({1'b0, q.cfg[bss_pkg::R_KP]}))
      + 48'(spdErr * $signed({1'b0, q.cfg[bss_pkg::R_KI]}))
      + 48'(dErr * $signed({1'b0, q.cfg[bss_pkg::R_KD]}));
   assign advProd = 24'((speedRpm - q.cfg[bss_pkg::R_ADV_START]) *
                        q.cfg[bss_pkg::R_ADV_SLOPE][7:0]);
   assign commNext = q.commAcc + 36'(spdIf.value *
                     q.cfg[bss_pkg::R_POLES][4:0]);
   assign wIdx = q.awready ? s_axi_awaddr[7:2] : q.awAddr[7:2];
   assign rIdx = s_axi_araddr[7:2];

   always_comb begin
      advDeg = '0;
      for (int k = 1; k <= int'(bss_pkg::ADV_MAX_DEG); k++) begin
         if (advProd >= 24'(k * bss_pkg::ADV_RPM_UNIT)) begin
            advDeg = 5'(k);
         end
      end
      if (speedRpm < q.cfg[bss_pkg::R_ADV_START]) begin
         advDeg = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Ramp interpolators
   assign dutyIf.load     = q.rampLoad;
   assign dutyIf.tick     = msTick;
   assign dutyIf.durMs    = rampMs;
   assign dutyIf.startVal = q.cfg[bss_pkg::R_RAMP_DUTY0];
   assign dutyIf.endVal   = q.cfg[bss_pkg::R_RAMP_DUTY1];
   assign spdIf.load      = q.rampLoad;
   assign spdIf.tick      = msTick;
   assign spdIf.durMs     = rampMs;
   assign spdIf.startVal  = q.cfg[bss_pkg::R_RAMP_SPD0];
   assign spdIf.endVal    = q.cfg[bss_pkg::R_RAMP_SPD1];

   bss_lerp u_dutyLerp (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .lp      (dutyIf.lerp)
   );

   bss_lerp u_spdLerp (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .lp      (spdIf.lerp)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      d.startReq = 1'b0;
      d.stopReq  = 1'b0;
      d.rampLoad = 1'b0;
      d.commStep = 1'b0;

      // Register bus, one write and one read outstanding
      if (s_axi_awvalid && q.awready) begin
         d.awHave = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.wHave = 1'b1;
         d.wData = s_axi_wdata;
         d.wStrb = s_axi_wstrb;
      end
      if (s_axi_bready && q.bvalid) begin
         d.bvalid = 1'b0;
      end
      if (d.awHave && d.wHave && !d.bvalid) begin
         d.awHave = 1'b0;
         d.wHave  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = wIdx <= bss_pkg::R_DUTY ? bss_pkg::RESP_OKAY
                                            : bss_pkg::RESP_SLVERR;
         if (wIdx < 6'(bss_pkg::NCFG)) begin
            if (d.wStrb[0]) begin
               d.cfg[wIdx[4:0]][7:0] = d.wData[7:0];
            end
            if (d.wStrb[1]) begin
               d.cfg[wIdx[4:0]][15:8] = d.wData[15:8];
            end
            if (wIdx == bss_pkg::R_CTRL && d.wStrb[0]) begin
               d.startReq = d.wData[bss_pkg::CTRL_START];
               d.stopReq  = d.wData[bss_pkg::CTRL_STOP];
               d.cfg[bss_pkg::R_CTRL] = d.cfg[bss_pkg::R_CTRL] &
                                        bss_pkg::CTRL_KEEP;
            end
         end
      end
      if (s_axi_rready && q.rvalid) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = bss_pkg::RESP_OKAY;
         d.rdata  = '0;
         if (rIdx < 6'(bss_pkg::NCFG)) begin
            d.rdata = 32'(q.cfg[rIdx[4:0]]);
         end else if (rIdx == bss_pkg::R_STATUS) begin
            d.rdata = 32'({q.phaseAdv, q.fault, q.highSpeed, q.st});
         end else if (rIdx == bss_pkg::R_DUTY) begin
            d.rdata = 32'(q.duty);
         end else begin
            d.rresp = bss_pkg::RESP_SLVERR;
         end
      end
      d.awready = !d.awHave && !d.bvalid;
      d.wready  = !d.wHave && !d.bvalid;
      d.arready = !d.rvalid;

      // Millisecond time base, restarted on entry to LOCK1, LOCK2 and RAMP
      d.msCnt = msTick ? '0 : q.msCnt + 18'h00001;
      if (msTick) begin
         d.phMs = q.phMs + 16'h0001;
      end

      // Crossover with hysteresis on both sides
      if (!q.highSpeed &&
          17'(speedErps) >= 17'(crossEff) + 17'(bss_pkg::HYST_ERPS)) begin
         d.highSpeed = 1'b1;
      end else if (q.highSpeed &&
                   speedErps < crossEff - bss_pkg::HYST_ERPS) begin
         d.highSpeed = 1'b0;
      end

      // Blanking counted in converter sample periods
      if (q.blankCnt != '0 && sampleTick) begin
         d.blankCnt = q.blankCnt - 5'h01;
      end

      unique case (q.st)
         bss_pkg::ST_IDLE, bss_pkg::ST_FAULT: d.duty = '0;
         bss_pkg::ST_LOCK1: begin
            d.duty   = q.cfg[bss_pkg::R_LOCK1_DUTY][6:0];
            d.sector = bss_pkg::SECTOR_LOCK1;
            if (q.phMs >= q.cfg[bss_pkg::R_LOCK1_MS]) begin
               d.st     = bss_pkg::ST_LOCK2;
               d.sector = bss_pkg::SECTOR_LOCK2;
               d.duty   = q.cfg[bss_pkg::R_LOCK2_DUTY][6:0];
               d.phMs   = '0;
               d.msCnt  = '0;
            end
         end
         bss_pkg::ST_LOCK2: begin
            d.duty = q.cfg[bss_pkg::R_LOCK2_DUTY][6:0];
            if (q.phMs >= q.cfg[bss_pkg::R_LOCK2_MS]) begin
               d.st       = bss_pkg::ST_RAMP;
               d.rampLoad = 1'b1;
               d.duty     = q.cfg[bss_pkg::R_RAMP_DUTY0][6:0];
               d.commAcc  = '0;
               d.msCnt    = '0;
            end
         end
         bss_pkg::ST_RAMP: begin
            if (!q.rampLoad) begin
               d.duty = dutyIf.value[6:0];
               // Open-loop commutation at the interpolated speed
               if (commNext >= bss_pkg::COMM_FULL) begin
                  d.commAcc  = commNext - bss_pkg::COMM_FULL;
                  d.commStep = 1'b1;
               end else begin
                  d.commAcc = commNext;
               end
               if (dutyIf.done && spdIf.done && d.duty == q.duty) begin
                  d.st     = bss_pkg::ST_RUN;
                  d.duty   = q.cfg[bss_pkg::R_INIT_DUTY][6:0];
                  d.pidAcc = 48'(q.cfg[bss_pkg::R_INIT_DUTY][6:0])
                             <<< bss_pkg::PID_FRAC;
                  d.e1     = '0;
                  d.e2     = '0;
                  d.ovfCnt = '0;
               end
            end
         end
         bss_pkg::ST_RUN: begin
            d.commStep = commEvt;
            if (potEn && !loopEn) begin
               d.duty = potDuty;
            end else if (potEn && sampleTick) begin
               if (pidSum < 0) begin
                  d.pidAcc = '0;
               end else if (pidSum > 48'(bss_pkg::PID_MAX)) begin
                  d.pidAcc = 48'(bss_pkg::PID_MAX);
               end else begin
                  d.pidAcc = pidSum;
               end
               d.e1   = spdErr;
               d.e2   = q.e1;
               d.duty = 7'(d.pidAcc >>> bss_pkg::PID_FRAC);
            end
            // Any genuine commutation proves sync and clears the count
            if (commEvt) begin
               d.ovfCnt = '0;
            end else if (commTimerOvf) begin
               d.ovfCnt = q.ovfCnt + 5'h01;
               if (5'(q.ovfCnt + 5'h01) >=
                   q.cfg[bss_pkg::R_SYNC_SENS][4:0]) begin
                  d.st    = bss_pkg::ST_FAULT;
                  d.fault = 1'b1;
                  d.duty  = '0;
               end
            end
         end
      endcase

      if (d.commStep) begin
         d.sector   = q.sector == bss_pkg::SECTOR_LAST ? '0
                                                      : q.sector + 3'h1;
         d.blankCnt = blankEff;
      end
      d.bemfValid = d.blankCnt == '0 && d.st == bss_pkg::ST_RUN;

      if (q.stopReq && q.st != bss_pkg::ST_IDLE) begin
         d.st       = bss_pkg::ST_IDLE;
         d.duty     = '0;
         d.commStep = 1'b0;
      end else if (q.startReq && (q.st == bss_pkg::ST_IDLE ||
                                  q.st == bss_pkg::ST_FAULT)) begin
         d.st      = bss_pkg::ST_LOCK1;
         d.fault   = 1'b0;
         d.sector  = bss_pkg::SECTOR_LOCK1;
         d.duty    = q.cfg[bss_pkg::R_LOCK1_DUTY][6:0];
         d.phMs    = '0;
         d.msCnt   = '0;
      end

      d.motorOn  = d.st != bss_pkg::ST_IDLE && d.st != bss_pkg::ST_FAULT;
      d.phaseAdv = d.motorOn ? advDeg : '0;
      if (!nrst) begin
         d = '0;
         d.st = bss_pkg::ST_IDLE;
         d.cfg[bss_pkg::R_POLES]     = bss_pkg::POLES_DFLT;
         d.cfg[bss_pkg::R_CROSS]     = bss_pkg::CROSS_DFLT;
         d.cfg[bss_pkg::R_SYNC_SENS] = bss_pkg::SENS_DFLT;
         d.cfg[bss_pkg::R_RAMP_MS]   = bss_pkg::RAMP_MS_MAX;
         d.cfg[bss_pkg::R_MAX_SPEED] = bss_pkg::SPEED_DFLT;
      end
   end

   always_ff @(posedge sys_clk) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////
   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rvalid  = q.rvalid;
   assign pwmDuty       = q.duty;
   assign sector        = q.sector;
   assign commStep      = q.commStep;
   assign motorOn       = q.motorOn;
   assign highSpeed     = q.highSpeed;
   assign phaseAdv      = q.phaseAdv;
   assign bemfValid     = q.bemfValid;
   assign syncFault     = q.fault;
endmodule

// File: verification/bss_stage_model.sv
`timescale 1ns/100ps
module bss_stage_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // From the sequencer, and the stall switch from the test
   input wire logic motorOn,
   input wire logic stall,
   // Sensed events back
   output logic     commEvt,
   output logic     commTimerOvf
);
   logic [2:0] tick;
   always_ff @(posedge sys_clk) begin
      tick <= (nrst && motorOn) ? tick + 3'h1 : 3'h0;
   end
   // Spinning rotor gives crossings, a stalled one only timer overflows
   assign commEvt = motorOn && !stall && tick == 3'h7;
   assign commTimerOvf = motorOn && stall && tick == 3'h7;
endmodule

// File: verification/bss_top_asserts.sv
`timescale 1ns/100ps
module bss_top_asserts (
   // Clock, reset, read answer
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Motor side
   input wire logic [15:0] speedErps,
   input wire logic        commTimerOvf,
   input wire logic        motorOn,
   input wire logic [2:0]  sector,
   input wire logic [4:0]  phaseAdv,
   input wire logic        highSpeed,
   input wire logic        bemfValid,
   input wire logic        syncFault
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_go; $rose(motorOn); endsequence
   sequence s_sec0; sector == bss_pkg::SECTOR_LOCK1 && !syncFault; endsequence
   property p_lock1; s_go |-> s_sec0; endproperty
   a_lock1: assert property (p_lock1)
      else $error("start off sector 0");
   property p_adv_cap; phaseAdv <= bss_pkg::ADV_MAX_DEG; endproperty
   a_adv_cap: assert property (p_adv_cap)
      else $error("advance over cap");
   property p_adv_off; !motorOn |-> phaseAdv == 5'h00; endproperty
   a_adv_off: assert property (p_adv_off)
      else $error("advance while off");
   property p_hs_on;
      $rose(highSpeed) |-> $past(speedErps) >= 16'h0064;
   endproperty
   a_hs_on: assert property (p_hs_on)
      else $error("high speed too early");
   property p_blank; bemfValid |-> motorOn; endproperty
   a_blank: assert property (p_blank)
      else $error("samples valid while off");
   property p_fault_off; syncFault |-> !motorOn; endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("drive left on after sync loss");
   property p_fault_cause;
      $rose(syncFault) |-> $past(commTimerOvf) || $past(commTimerOvf, 2);
   endproperty
   a_fault_cause: assert property (p_fault_cause)
      else $error("fault without overflow");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read answer dropped");
endmodule
bind bss_top bss_top_asserts u_chk (.sys_clk, .nrst, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .speedErps, .commTimerOvf, .motorOn,
   .sector, .phaseAdv, .highSpeed, .bemfValid, .syncFault);

// File: verification/bss_top_tb.sv
`timescale 1ns/100ps
module bss_top_tb;
   logic        sys_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sampleTick;
   logic        commEvt, commTimerOvf, commStep, motorOn, highSpeed;
   logic        bemfValid, syncFault, stall, seenEnd;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [15:0] speedRpm, speedErps;
   logic [9:0]  potValue;
   logic [6:0]  pwmDuty;
   logic [4:0]  phaseAdv;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  sector;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          num_errors, comparisons, cyc;
   ////////////////////////////////////////
   bss_top #(.MS_CYCLES(20)) DUT (.sys_clk, .nrst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .potValue,
      .speedRpm, .speedErps, .sampleTick, .commEvt, .commTimerOvf,
      .pwmDuty, .sector, .commStep, .motorOn, .highSpeed, .phaseAdv,
      .bemfValid, .syncFault);
   bss_stage_model u_stage (.sys_clk, .nrst, .motorOn, .stall, .commEvt,
      .commTimerOvf);
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      sampleTick <= cyc[3:0] == 4'h0;
      if (pwmDuty === 7'h28) seenEnd <= 1'b1;
      if (cyc == 30000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input bit ok, input string m);
      comparisons++;
      if (!ok) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [5:0] i, input logic [15:0] d);
      logic a = 1'b1, w = 1'b1;
      @(posedge sys_clk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) a = 1'b0;
         if (s_axi_wready === 1'b1) w = 1'b0;
         s_axi_awvalid <= a;
         s_axi_wvalid <= w;
      end while (a || w);
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp === bss_pkg::RESP_OKAY, "write answer");
   endtask
   task automatic rc(input logic [5:0] i, input logic [31:0] e,
                     input logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      // Late rready makes the slave hold its answer
      @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata === e && s_axi_rresp === r, "read");
   endtask
   task automatic waitd(input logic [6:0] v, input int n, output int k);
      k = 0;
      while (pwmDuty !== v && k < n) begin
         @(posedge sys_clk);
         k++;
      end
      chk(pwmDuty === v, "duty");
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      rc(bss_pkg::R_POLES, 32'h4, bss_pkg::RESP_OKAY);
      rc(bss_pkg::R_CROSS, 32'hFA, bss_pkg::RESP_OKAY);
      rc(bss_pkg::R_RAMP_MS, 32'h1964, bss_pkg::RESP_OKAY);
      rc(6'h17, 32'h0, bss_pkg::RESP_SLVERR);
      $display("reset done");
   endtask
   task automatic t_start;
      int k;
      wr(bss_pkg::R_LOCK1_MS, 16'h0002);
      wr(bss_pkg::R_LOCK2_MS, 16'h0003);
      wr(bss_pkg::R_LOCK1_DUTY, 16'h000A);
      wr(bss_pkg::R_LOCK2_DUTY, 16'h0014);
      wr(bss_pkg::R_RAMP_DUTY0, 16'h001E);
      wr(bss_pkg::R_RAMP_DUTY1, 16'h0028);
      wr(bss_pkg::R_RAMP_MS, 16'h0064);
      wr(bss_pkg::R_INIT_DUTY, 16'h0019);
      potValue <= 10'h3FF;
      wr(bss_pkg::R_CTRL, 16'h0001);
      waitd(7'h0A, 4, k);
      chk(sector === 3'h0 && motorOn === 1'b1, "lock 1");
      waitd(7'h14, 50, k);
      chk(sector === 3'h1 && k >= 38 && k <= 42, "lock 1 time");
      waitd(7'h1E, 70, k);
      chk(k >= 58 && k <= 62, "lock 2 time");
      repeat (5000) @(posedge sys_clk);
      chk(pwmDuty >= 7'h22 && pwmDuty <= 7'h24, "ramp middle");
      waitd(7'h19, 5100, k);
      chk(k >= 4990 && k <= 5020 && seenEnd, "ramp end");
      repeat (100) @(posedge sys_clk);
      chk(pwmDuty === 7'h19, "pot off");
      $display("start done");
   endtask
   task automatic t_pot;
      int k;
      wr(bss_pkg::R_CTRL, 16'h0008);
      waitd(7'h64, 50, k);
      potValue <= 10'h000;
      waitd(7'h00, 50, k);
      wr(bss_pkg::R_KI, 16'h0001);
      wr(bss_pkg::R_CTRL, 16'h000C);
      potValue <= 10'h3FF;
      waitd(7'h64, 1300, k);
      chk(k > 1100, "speed loop");
      $display("pot done");
   endtask
   task automatic t_adv;
      logic [15:0] rpm [5] = '{16'h03E7, 16'h03E8, 16'h05DC, 16'h0F9F,
                               16'h2710};
      logic [4:0] adv [5] = '{5'h00, 5'h00, 5'h05, 5'h1D, 5'h1E};
      wr(bss_pkg::R_ADV_START, 16'h03E8);
      wr(bss_pkg::R_ADV_SLOPE, 16'h000A);
      for (int i = 0; i < 5; i++) begin
         speedRpm <= rpm[i];
         repeat (4) @(posedge sys_clk);
         chk(phaseAdv === adv[i], "advance");
      end
      $display("advance done");
   endtask
   task automatic t_hs;
      logic [15:0] erps [5] = '{16'h012B, 16'h012C, 16'h00C9, 16'h00C8,
                                16'h00C7};
      logic hs [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         speedErps <= erps[i];
         repeat (4) @(posedge sys_clk);
         chk(highSpeed === hs[i], "speed mode");
      end
      $display("crossover done");
   endtask
   task automatic t_fault;
      int k = 0, n = 0;
      wr(bss_pkg::R_SYNC_SENS, 16'h0003);
      stall <= 1'b1;
      while (syncFault !== 1'b1 && k < 60) begin
         @(posedge sys_clk);
         k++;
         n += int'(commTimerOvf === 1'b1);
      end
      chk(n == 3 && motorOn === 1'b0, "sync loss");
      $display("fault done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      {sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, sampleTick, stall, seenEnd} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, potValue} = '0;
      {speedRpm, speedErps, num_errors, comparisons, cyc} = '0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_start();
      t_pot();
      t_adv();
      t_hs();
      t_fault();
      tally_and_finish();
   end
endmodule
